// ### ldsf_pkg.sv
/*
  Shared constants, state codes and carriers for the LED driver state and fault controller.
  Assumes a single 50 MHz system clock; all cycle counts derive from it.
*/
package ldsf_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned SOFT_START_MS = 25;
  localparam int unsigned BOOST_STARTUP_STATE_MS = 50;
  localparam int unsigned RECOVERY_MS = 100;
  localparam int unsigned DISCHARGE_MS = 400;
  localparam int unsigned SERIAL_TO_MS = 500;
  localparam int unsigned SHORT_MS = 5;
  localparam int unsigned SOFT_START_CYC = SOFT_START_MS * CYC_PER_MS;
  localparam int unsigned BOOST_STARTUP_STATE_CYC = BOOST_STARTUP_STATE_MS * CYC_PER_MS;
  localparam int unsigned RECOVERY_CYC = RECOVERY_MS * CYC_PER_MS;
  localparam int unsigned DISCHARGE_CYC = DISCHARGE_MS * CYC_PER_MS;
  localparam int unsigned SERIAL_TO_CYC = SERIAL_TO_MS * CYC_PER_MS;
  localparam int unsigned SHORT_CYC = SHORT_MS * CYC_PER_MS;
  localparam int unsigned TMR_W = 25;
  localparam int unsigned NCH_DEF = 6;
  localparam logic [6:0] ADDR_BASE = 7'h2A;
  localparam logic [6:0] ADDR_ALT = 7'h2B;
  localparam logic [11:0] ISET_CODE = 12'h03FF;
  localparam logic [11:0] CUR_RST = 12'h0FFF;
  localparam logic [15:0] BRT_RST = 16'h0000;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] OFF_BRT = 8'h00;
  localparam logic [7:0] OFF_CUR = 8'h02;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h12;
  localparam logic [7:0] OFF_STRINGS = 8'h13;
  localparam logic [7:0] OFF_STATE = 8'h14;
  localparam logic [7:0] OFF_DUTY = 8'h16;
  localparam int unsigned F_ISET = 0;
  localparam int unsigned F_THERM = 1;
  localparam int unsigned F_OPEN = 2;
  localparam int unsigned F_SHORT = 3;
  localparam int unsigned F_GND = 4;
  localparam int unsigned F_INV = 5;
  localparam int unsigned F_SER = 6;
  localparam int unsigned NFLAG = 7;
  localparam int unsigned CLR_POS = 8;

  typedef enum logic [8:0] {
    ST_INIT = 9'b0_0000_0001,
    ST_STANDBY = 9'b0_0000_0010,
    ST_SOFTSTART = 9'b0_0000_0100,
    ST_BOOSTSU = 9'b0_0000_1000,
    ST_NORMAL = 9'b0_0001_0000,
    ST_RECOVERY = 9'b0_0010_0000,
    ST_LATCH = 9'b0_0100_0000,
    ST_SHUTDOWN = 9'b0_1000_0000,
    ST_OFF = 9'b1_0000_0000
  } ldsf_state_e;

  typedef enum logic [4:0] {
    I_IDLE = 5'b0_0001,
    I_RX = 5'b0_0010,
    I_ACK = 5'b0_0100,
    I_TX = 5'b0_1000,
    I_MACK = 5'b1_0000
  } ldsf_ser_e;

  typedef struct packed {
    logic s_curve_smoothing_enable;
    logic [2:0] ramp_duration_select;
    logic [2:0] dither_select;
    logic brightness_source_select;
  } ldsf_cfg_s;

  typedef struct packed {
    logic serial_error_flag;
    logic invalid_string_flag;
    logic short_to_ground_flag;
    logic internal_short_flag;
    logic open_string_flag;
    logic thermal_shutdown_flag;
    logic current_set_short_flag;
  } ldsf_flags_s;
endpackage

// ### ldsf_ctrl.sv
/*
  Operating state machine, fault reactions and serial register target of the LED driver.
  Assumes comparator, detection and pin inputs are asynchronous; all pass two flip-flops.
*/
// Functional notes
// - Current-set pin low: set flag, interrupt, force sink code 0x3FF, no recovery.
// - Over-temperature: flag, interrupt, go standby; restart once indication clears.
// - Low headroom with boost at maximum: flag open string, disable it until power cycle.
// - Headroom above short threshold over 5 ms, another below: flag short, disable string.
// - Used output low under test current: flag, recovery, restart after 100 ms.
// - Unused output not grounded at init: flag invalid string, keep operating.
// - Serial command 500 ms without stop: reset serial logic, flag error, interrupt.
// - Enable low: boost, switch, outputs off; discharge 400 ms then power down.
// - After reset release run initialization: regulator, trim load, resistor detection.
// - Standby moves straight to soft start when over-temperature is clear; other faults do not hold it.
// - Soft start lasts 25 ms with supply and short-to-ground faults enabled.
// - Boost start-up ramps 50 ms at reduced limit; boost faults active from here.
// - Normal mode drives LEDs only for nonzero brightness; LED faults active.
// - Recovery holds all off 100 ms, restarts if enabled and brightness nonzero.
// - All strings disabled enters latch fault; only enable low exits.
// - Target address 0x2A or 0x2B chosen by mode resistor at initialization.
// - Write: address+W, register address, two value bytes.
// - Read: address+W, register address, repeated address+R, two value bytes returned.
// - Configuration writes accepted standby through normal; pins alone suffice otherwise.
// - Status clears only with status and clear bit both one; interrupt alerts host.
// - Configuration picks brightness from measured pin duty or serial value.
// - Configuration holds 3-bit dither, ramp duration select and S-curve enable.
`timescale 1ns/10ps
module ldsf_ctrl
  import ldsf_pkg::*;
#(
  parameter int unsigned NCH = NCH_DEF,
  parameter int unsigned SS_CYC = SOFT_START_CYC,
  parameter int unsigned BSU_CYC = BOOST_STARTUP_STATE_CYC,
  parameter int unsigned REC_CYC = RECOVERY_CYC,
  parameter int unsigned DIS_CYC = DISCHARGE_CYC,
  parameter int unsigned TO_CYC = SERIAL_TO_CYC,
  parameter int unsigned SHT_CYC = SHORT_CYC
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic en_pin,
  input wire logic pwm_pin,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic init_done,
  input wire logic mode_addr_alt,
  input wire logic [NCH-1:0] string_used,
  input wire logic unused_not_grounded,
  input wire logic iset_low,
  input wire logic over_temp,
  input wire logic boost_at_max,
  input wire logic [NCH-1:0] headroom_low,
  input wire logic [NCH-1:0] headroom_high,
  input wire logic [NCH-1:0] gnd_test_low,
  output ldsf_state_e state,
  output logic plfet_en,
  output logic boost_en,
  output logic boost_low_ilim,
  output logic discharge_en,
  output logic powered_down,
  output logic vin_fault_en,
  output logic boost_fault_en,
  output logic led_fault_en,
  output logic gnd_test_en,
  output logic [NCH-1:0] led_drive,
  output logic [NCH-1:0] string_fault_flags,
  output ldsf_flags_s flags,
  output logic int_out,
  output logic [11:0] sink_current_code,
  output logic [15:0] brightness,
  output ldsf_cfg_s cfg
);
  localparam int unsigned AW = 10 + 4 * NCH;
  localparam int unsigned SW = $clog2(SHT_CYC + 1);
  logic [AW-1:0] sync_m_q, sync_q;
  logic scl_p_q, sda_p_q;
  logic en_s, pwm_s, scl_s, sda_s, init_s, mode_s, unused_s, iset_s, therm_s, bmax_s;
  logic [NCH-1:0] used_s, hrl_s, hrh_s, gnd_s;
  // Edges compare the second and third stages; the first stage feeds nothing but the second
  always_ff @(posedge clk_sys)
  begin
    sync_m_q <= {en_pin, pwm_pin, scl_pin, sda_in, init_done, mode_addr_alt, unused_not_grounded,
                 iset_low, over_temp, boost_at_max, string_used, headroom_low, headroom_high, gnd_test_low};
    sync_q <= sync_m_q;
    scl_p_q <= scl_s;
    sda_p_q <= sda_s;
  end
  assign {en_s, pwm_s, scl_s, sda_s, init_s, mode_s, unused_s, iset_s, therm_s, bmax_s,
          used_s, hrl_s, hrh_s, gnd_s} = sync_q;

  // Fixed-window duty measurement keeps the pin path free of a divider
  logic [15:0] win_q, win_d, hi_q, hi_d, duty_q, duty_d;
  always_comb
  begin
    win_d = win_q + 16'h0001;
    hi_d = hi_q + {15'h0000, pwm_s};
    duty_d = duty_q;
    if (win_q == 16'hFFFF)
    begin
      duty_d = hi_q;
      hi_d = 16'h0000;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      win_q <= 16'h0000;
      hi_q <= 16'h0000;
      duty_q <= 16'h0000;
    end
    else
    begin
      win_q <= win_d;
      hi_q <= hi_d;
      duty_q <= duty_d;
    end
  end

  // Serial target
  ldsf_ser_e ist_q, ist_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wdh_q, wdh_d;
  logic [2:0] byte_q, byte_d;
  logic rw_q, rw_d, oe_q, oe_d, busy_q, busy_d, wr_fire, to_ev, addr_alt_q, addr_alt_d;
  logic [TMR_W-1:0] to_q, to_d;
  logic [15:0] rd_word, wdata;
  logic rise, fall, start, stop;
  logic [6:0] my_addr;
  logic [7:0] cfg_q, cfg_d;
  logic [NFLAG-1:0] flags_q, flags_d, ev, clr;
  logic [NCH-1:0] dis_q, dis_d, used_q, used_d;
  logic [11:0] cur_q, cur_d;
  logic [15:0] brt_q, brt_d, brt_sel;
  ldsf_state_e st_q, st_d;
  assign rise = scl_s & ~scl_p_q;
  assign fall = ~scl_s & scl_p_q;
  assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign my_addr = addr_alt_q ? ADDR_ALT : ADDR_BASE;
  assign wdata = {wdh_q, sh_q};
  always_comb
  begin
    case (ptr_q)
      OFF_BRT: rd_word = brt_q;
      OFF_CUR: rd_word = {4'h0, cur_q};
      OFF_CFG: rd_word = {8'h00, cfg_q};
      OFF_STATUS: rd_word = {9'h000, flags_q};
      OFF_STRINGS: rd_word = {{(16-NCH){1'b0}}, dis_q};
      OFF_STATE: rd_word = {7'h00, st_q};
      OFF_DUTY: rd_word = duty_q;
      default: rd_word = 16'h0000;
    endcase
  end
  always_comb
  begin
    ist_d = ist_q;
    bit_d = bit_q;
    sh_d = sh_q;
    byte_d = byte_q;
    rw_d = rw_q;
    ptr_d = ptr_q;
    wdh_d = wdh_q;
    oe_d = oe_q;
    busy_d = busy_q;
    to_d = busy_q ? to_q + {{(TMR_W-1){1'b0}}, 1'b1} : '0;
    wr_fire = 1'b0;
    to_ev = 1'b0;
    if (to_q == TMR_W'(TO_CYC - 1))
    begin
      to_ev = 1'b1;
      ist_d = I_IDLE;
      busy_d = 1'b0;
      oe_d = 1'b0;
      to_d = '0;
    end
    else if (start)
    begin
      ist_d = I_RX;
      bit_d = 4'h0;
      byte_d = 3'h0;
      busy_d = 1'b1;
      oe_d = 1'b0;
      to_d = '0;
    end
    else if (stop)
    begin
      ist_d = I_IDLE;
      busy_d = 1'b0;
      oe_d = 1'b0;
    end
    else
    begin
      case (ist_q)
        I_RX:
          if (rise)
          begin
            sh_d = {sh_q[6:0], sda_s};
            bit_d = bit_q + 4'h1;
          end
          else if (fall && bit_q == 4'h8)
          begin
            ist_d = I_ACK;
            oe_d = 1'b1;
            bit_d = 4'h0;
            byte_d = (byte_q == 3'h7) ? byte_q : byte_q + 3'h1;
            case (byte_q)
              3'h0:
                if (sh_q[7:1] != my_addr)
                begin
                  ist_d = I_IDLE;
                  oe_d = 1'b0;
                end
                else
                  rw_d = sh_q[0];
              3'h1: ptr_d = sh_q;
              3'h2: wdh_d = sh_q;
              3'h3: wr_fire = ~rw_q;
              default: ;
            endcase
          end
        I_ACK:
          if (fall)
          begin
            bit_d = 4'h0;
            if (rw_q)
            begin
              ist_d = I_TX;
              sh_d = rd_word[15:8];
              oe_d = ~rd_word[15];
            end
            else
            begin
              ist_d = I_RX;
              oe_d = 1'b0;
            end
          end
        I_TX:
          if (rise)
            bit_d = bit_q + 4'h1;
          else if (fall)
          begin
            if (bit_q == 4'h8)
            begin
              ist_d = I_MACK;
              oe_d = 1'b0;
            end
            else
            begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        I_MACK:
          if (rise && sda_s)
            ist_d = I_IDLE;
          else if (fall)
          begin
            ist_d = I_TX;
            bit_d = 4'h0;
            sh_d = rd_word[7:0];
            oe_d = ~rd_word[7];
          end
        default: ist_d = I_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ist_q <= I_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      byte_q <= 3'h0;
      rw_q <= 1'b0;
      ptr_q <= 8'h00;
      wdh_q <= 8'h00;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
      to_q <= '0;
    end
    else
    begin
      ist_q <= ist_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      byte_q <= byte_d;
      rw_q <= rw_d;
      ptr_q <= ptr_d;
      wdh_q <= wdh_d;
      oe_q <= oe_d;
      busy_q <= busy_d;
      to_q <= to_d;
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;

  // Operating state, string faults and registers
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [SW-1:0] scnt_q [NCH], scnt_d [NCH];
  logic [NCH-1:0] active, open_ev, short_ev, gnd_chk;
  logic gnd_ev, all_dis, cfg_ok, init_exit;
  assign active = used_q & ~dis_q;
  assign brt_sel = cfg_q[0] ? brt_q : duty_q;
  assign cfg_ok = st_q inside {ST_STANDBY, ST_SOFTSTART, ST_BOOSTSU, ST_NORMAL};
  always_comb
  begin
    led_drive = (st_q == ST_NORMAL && brt_sel != 16'h0000) ? active : '0;
    open_ev = (st_q == ST_NORMAL) ? active & hrl_s & {NCH{bmax_s}} : '0;
    for (int i = 0; i < NCH; i++)
    begin
      scnt_d[i] = '0;
      short_ev[i] = 1'b0;
      if (st_q == ST_NORMAL && active[i] && hrh_s[i] && |(active & ~hrh_s))
      begin
        scnt_d[i] = (scnt_q[i] == SW'(SHT_CYC)) ? scnt_q[i] : scnt_q[i] + SW'(1);
        short_ev[i] = (scnt_q[i] == SW'(SHT_CYC));
      end
    end
    gnd_chk = (st_q == ST_SOFTSTART) ? used_q :
              (st_q inside {ST_BOOSTSU, ST_NORMAL}) ? used_q & ~led_drive : '0;
    gnd_ev = |(gnd_chk & gnd_s);
    dis_d = (st_q == ST_INIT) ? '0 : dis_q | open_ev | short_ev;
    all_dis = (used_q != '0) && ((used_q & ~dis_d) == '0);
    st_d = st_q;
    case (st_q)
      ST_INIT: if (init_s) st_d = ST_STANDBY;
      ST_STANDBY: if (!therm_s) st_d = ST_SOFTSTART;
      ST_SOFTSTART:
        if (gnd_ev) st_d = ST_RECOVERY;
        else if (tmr_q == TMR_W'(SS_CYC - 1)) st_d = ST_BOOSTSU;
      ST_BOOSTSU:
        if (gnd_ev) st_d = ST_RECOVERY;
        else if (tmr_q == TMR_W'(BSU_CYC - 1)) st_d = ST_NORMAL;
      ST_NORMAL:
        if (gnd_ev) st_d = ST_RECOVERY;
        else if (all_dis) st_d = ST_LATCH;
      ST_RECOVERY: if (tmr_q >= TMR_W'(REC_CYC - 1) && brt_sel != 16'h0000) st_d = ST_STANDBY;
      ST_LATCH: st_d = ST_LATCH;
      ST_SHUTDOWN: if (tmr_q == TMR_W'(DIS_CYC - 1)) st_d = ST_OFF;
      ST_OFF: if (en_s) st_d = ST_INIT;
      default: st_d = ST_INIT;
    endcase
    if (therm_s && st_q inside {ST_SOFTSTART, ST_BOOSTSU, ST_NORMAL}) st_d = ST_STANDBY;
    if (!en_s && !(st_q inside {ST_SHUTDOWN, ST_OFF})) st_d = ST_SHUTDOWN;
    tmr_d = (st_d != st_q) ? '0 : tmr_q + {{(TMR_W-1){1'b0}}, ~&tmr_q};
    init_exit = (st_q == ST_INIT) && init_s;
    used_d = init_exit ? used_s : used_q;
    addr_alt_d = init_exit ? mode_s : addr_alt_q;
    ev = '0;
    ev[F_ISET] = iset_s;
    ev[F_THERM] = therm_s && !(st_q inside {ST_INIT, ST_SHUTDOWN, ST_OFF});
    ev[F_OPEN] = |open_ev;
    ev[F_SHORT] = |short_ev;
    ev[F_GND] = gnd_ev;
    ev[F_INV] = init_exit && unused_s;
    ev[F_SER] = to_ev;
    // A fault arriving with its clear keeps the bit set
    clr = (wr_fire && ptr_q == OFF_STATUS) ? wdata[NFLAG-1:0] & wdata[CLR_POS+NFLAG-1:CLR_POS] : '0;
    flags_d = (flags_q & ~clr) | ev;
    cfg_d = (wr_fire && cfg_ok && ptr_q == OFF_CFG) ? wdata[7:0] : cfg_q;
    brt_d = (wr_fire && cfg_ok && ptr_q == OFF_BRT) ? wdata : brt_q;
    cur_d = (wr_fire && cfg_ok && ptr_q == OFF_CUR) ? wdata[11:0] : cur_q;
    if (iset_s) cur_d = ISET_CODE;
  end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q <= ST_INIT;
      tmr_q <= '0;
      dis_q <= '0;
      used_q <= '0;
      addr_alt_q <= 1'b0;
      flags_q <= '0;
      cfg_q <= CFG_RST;
      brt_q <= BRT_RST;
      cur_q <= CUR_RST;
      for (int i = 0; i < NCH; i++) scnt_q[i] <= '0;
    end
    else
    begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      dis_q <= dis_d;
      used_q <= used_d;
      addr_alt_q <= addr_alt_d;
      flags_q <= flags_d;
      cfg_q <= cfg_d;
      brt_q <= brt_d;
      cur_q <= cur_d;
      for (int i = 0; i < NCH; i++) scnt_q[i] <= scnt_d[i];
    end
  end
  assign state = st_q;
  assign plfet_en = st_q inside {ST_SOFTSTART, ST_BOOSTSU, ST_NORMAL};
  assign boost_en = st_q inside {ST_BOOSTSU, ST_NORMAL};
  assign boost_low_ilim = (st_q == ST_BOOSTSU);
  assign discharge_en = (st_q == ST_SHUTDOWN);
  assign powered_down = (st_q == ST_OFF);
  assign vin_fault_en = plfet_en;
  assign gnd_test_en = plfet_en;
  assign boost_fault_en = boost_en;
  assign led_fault_en = (st_q == ST_NORMAL);
  assign string_fault_flags = dis_q;
  assign flags = ldsf_flags_s'(flags_q);
  assign int_out = |flags_q;
  assign sink_current_code = cur_q;
  assign brightness = brt_sel;
  assign cfg = ldsf_cfg_s'(cfg_q);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_iset_force: assert property (iset_s |=> cur_q == ISET_CODE && flags_q[F_ISET] &&
    (st_q != ST_RECOVERY || $past(gnd_ev || st_q == ST_RECOVERY))) else $error("iset");
  a_therm_stby: assert property (therm_s && en_s && st_q inside {ST_SOFTSTART, ST_NORMAL} |=> st_q == ST_STANDBY) else $error("therm");
  a_open_disable: assert property (|open_ev |=> flags_q[F_OPEN] && (dis_q & $past(open_ev)) == $past(open_ev)) else $error("open");
  a_short_disable: assert property (|short_ev |=> flags_q[F_SHORT] && (dis_q & $past(short_ev)) == $past(short_ev)) else $error("short");
  a_gnd_recover: assert property (gnd_ev && en_s && !therm_s |=> st_q == ST_RECOVERY ##1 st_q == ST_RECOVERY) else $error("gnd");
  a_serial_timeout: assert property (to_q == TMR_W'(TO_CYC - 1) |=> ist_q == I_IDLE && !sda_oe && flags_q[F_SER]) else $error("timeout");
  a_shutdown_off: assert property (st_q == ST_SHUTDOWN |-> !boost_en && !plfet_en && led_drive == '0 && discharge_en) else $error("shdn");
  a_softstart_en: assert property (st_q == ST_SOFTSTART |-> vin_fault_en && gnd_test_en && !boost_en) else $error("ss");
  a_led_nonzero: assert property (led_drive != '0 |-> st_q == ST_NORMAL && brightness != 16'h0000) else $error("led");
  a_recovery_hold: assert property ($rose(st_q == ST_RECOVERY) |-> (st_q == ST_RECOVERY && !plfet_en)[*8]) else $error("rec");
  a_latch_hold: assert property (st_q == ST_LATCH && en_s |=> st_q == ST_LATCH) else $error("latch");
  a_flag_sticky: assert property (!(wr_fire && ptr_q == OFF_STATUS) |=> ($past(flags_q) & ~flags_q) == '0) else $error("clr");
  a_cfg_gate: assert property (wr_fire && !cfg_ok |=> $stable(cfg_q) && $stable(brt_q)) else $error("cfg");
  c_normal: cover property (st_q == ST_NORMAL && led_drive != '0);
  c_latch: cover property (st_q == ST_LATCH);
  c_recovery: cover property (st_q == ST_RECOVERY ##1 st_q == ST_STANDBY);
  c_write: cover property (wr_fire && cfg_ok);
  c_read: cover property (ist_q == I_MACK ##[1:40] ist_q == I_TX);
endmodule

// ### ldsf_host.sv
/* I2C host model that drives the serial target of the LED driver controller.
   Assumes the bench resolves the open-drain data wire with a pull-up and feeds it back on sda. */
`timescale 1ns/10ps
module ldsf_host (
  input wire logic clk_sys,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  logic [15:0] rd_val;
  logic ack;
  initial
  begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  // Two system cycles per quarter bit give the 160 ns serial clock
  task automatic step(input logic c, input logic d);
    scl = c;
    sda_low = d;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // Data only moves while the clock is low
  task automatic bit_x(input logic b, output logic s);
    step(1'h0, !b);
    step(1'h1, !b);
    s = sda;
    step(1'h1, !b);
    step(1'h0, !b);
  endtask
  // Also a repeated start: data is released before the clock rises
  task automatic start();
    step(scl, 1'h0);
    step(1'h1, 1'h0);
    step(1'h1, 1'h1);
    step(1'h0, 1'h1);
  endtask
  task automatic stop();
    step(1'h0, 1'h1);
    step(1'h1, 1'h1);
    step(1'h1, 1'h0);
  endtask
  task automatic xfer(input logic [7:0] d, input logic hack, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(!hack, a);
    a = !a;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [15:0] v);
    logic [7:0] q;
    logic [3:0] a;
    start();
    xfer({dev, 1'h0}, 1'h0, q, a[0]);
    xfer(ra, 1'h0, q, a[1]);
    xfer(v[15:8], 1'h0, q, a[2]);
    xfer(v[7:0], 1'h0, q, a[3]);
    stop();
    ack = &a;
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] ra);
    logic [7:0] q;
    logic [3:0] a;
    start();
    xfer({dev, 1'h0}, 1'h0, q, a[0]);
    xfer(ra, 1'h0, q, a[1]);
    start();
    xfer({dev, 1'h1}, 1'h0, q, a[2]);
    xfer(8'hFF, 1'h1, rd_val[15:8], a[3]);
    xfer(8'hFF, 1'h0, rd_val[7:0], a[3]);
    stop();
    ack = &a[2:0];
  endtask
endmodule

// ### tb.sv
/* Self-checking bench for the LED driver state and fault controller.
   Assumes ldsf_pkg and ldsf_host compile first; long counts are shortened by parameter. */
`timescale 1ns/10ps
module tb;
  import ldsf_pkg::*;
  localparam int SS = 50, BSU = 60, REC = 80, DIS = 100, TO = 2000, SHT = 30;
  logic clk_sys, sda, scl, sda_low, sda_oe, plfet_en, boost_en, boost_low_ilim, discharge_en, powered_down;
  logic rst = 1'h1, en_pin = 1'h1, init_done = 1'h0, iset_low = 1'h0, over_temp = 1'h0, boost_at_max = 1'h0;
  logic pwm_pin = 1'h1, mode_addr_alt = 1'h0, sda_out;
  logic [5:0] headroom_low = 6'h00, headroom_high = 6'h00, gnd_test_low = 6'h00, led_drive, string_fault_flags;
  logic vin_fault_en, gnd_test_en, boost_fault_en, led_fault_en, int_out, a;
  logic [7:0] q;
  logic [11:0] sink_current_code;
  logic [15:0] brightness;
  ldsf_state_e state;
  ldsf_flags_s flags;
  ldsf_cfg_s cfg;
  int fail_count = 0;
  int checks = 0;
  int n;
  // Pull-up on the data wire: low whenever either party pulls
  assign sda = (sda_low || (sda_oe && !sda_out)) ? 1'h0 : 1'h1;
  ldsf_host host (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low));
  ldsf_ctrl #(.NCH(6), .SS_CYC(SS), .BSU_CYC(BSU), .REC_CYC(REC), .DIS_CYC(DIS), .TO_CYC(TO), .SHT_CYC(SHT)) dut (
    .clk_sys(clk_sys), .rst(rst), .en_pin(en_pin), .pwm_pin(pwm_pin), .scl_pin(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .init_done(init_done), .mode_addr_alt(mode_addr_alt), .string_used(6'h0F),
    .unused_not_grounded(1'h1),
    .iset_low(iset_low), .over_temp(over_temp), .boost_at_max(boost_at_max), .headroom_low(headroom_low),
    .headroom_high(headroom_high), .gnd_test_low(gnd_test_low), .state(state), .plfet_en(plfet_en),
    .boost_en(boost_en), .boost_low_ilim(boost_low_ilim), .discharge_en(discharge_en), .powered_down(powered_down),
    .vin_fault_en(vin_fault_en), .boost_fault_en(boost_fault_en), .led_fault_en(led_fault_en),
    .gnd_test_en(gnd_test_en), .led_drive(led_drive), .string_fault_flags(string_fault_flags), .flags(flags),
    .int_out(int_out), .sink_current_code(sink_current_code), .brightness(brightness), .cfg(cfg)
  );
  initial
  begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic tk(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded wait; n returns the cycles spent
  task automatic wst(input ldsf_state_e s);
    n = 0;
    while (state !== s && n < 5000)
    begin
      tk(1);
      n++;
    end
    chk(state, s);
  endtask
  task automatic conclude();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #1800000;
    fail_count++;
    conclude();
  end
  initial
  begin
    tk(6);
    rst = 1'h0;
    tk(8);
    chk({state, sink_current_code, flags}, {ST_INIT, CUR_RST, 7'h00});
    init_done = 1'h1;
    wst(ST_SOFTSTART);
    chk({plfet_en, vin_fault_en, gnd_test_en, boost_en}, 4'hE);
    wst(ST_BOOSTSU);
    chk({1'(n > SS - 3 && n < SS + 3), boost_low_ilim, boost_fault_en, led_fault_en}, 4'hE);
    wst(ST_NORMAL);
    chk({1'(n > BSU - 3 && n < BSU + 3), flags.invalid_string_flag, int_out, led_fault_en}, 4'hF);
    host.wr(ADDR_BASE, OFF_CFG, 16'h00B7);
    chk({host.ack, cfg}, {1'h1, 8'hB7});
    host.wr(ADDR_BASE, OFF_BRT, 16'hA5C3);
    chk({brightness, led_drive}, {16'hA5C3, 6'h0F});
    host.rd(ADDR_BASE, OFF_BRT);
    chk({host.ack, host.rd_val}, {1'h1, 16'hA5C3});
    host.wr(ADDR_ALT, OFF_BRT, 16'h0000);
    chk({host.ack, brightness}, {1'h0, 16'hA5C3});
    host.wr(ADDR_BASE, OFF_BRT, 16'h0000);
    chk(led_drive, 6'h00);
    host.wr(ADDR_BASE, OFF_BRT, 16'h00FF);
    iset_low = 1'h1;
    tk(5);
    chk({flags.current_set_short_flag, int_out, sink_current_code, state}, {2'h3, ISET_CODE, ST_NORMAL});
    iset_low = 1'h0;
    host.wr(ADDR_BASE, OFF_STATUS, 16'h0001);
    chk(flags.current_set_short_flag, 1'h1);
    host.wr(ADDR_BASE, OFF_STATUS, 16'h0101);
    chk(flags.current_set_short_flag, 1'h0);
    boost_at_max = 1'h1;
    headroom_low = 6'h01;
    tk(5);
    chk({flags.open_string_flag, string_fault_flags, led_drive}, {1'h1, 6'h01, 6'h0E});
    boost_at_max = 1'h0;
    headroom_low = 6'h00;
    headroom_high = 6'h02;
    tk(SHT - 4);
    chk(flags.internal_short_flag, 1'h0);
    tk(10);
    chk({flags.internal_short_flag, string_fault_flags, led_drive}, {1'h1, 6'h03, 6'h0C});
    headroom_high = 6'h00;
    gnd_test_low = 6'h01;
    wst(ST_RECOVERY);
    gnd_test_low = 6'h00;
    chk({flags.short_to_ground_flag, plfet_en, boost_en, led_drive}, {2'h2, 7'h00});
    wst(ST_STANDBY);
    chk(1'(n > REC - 3 && n < REC + 3), 1'h1);
    wst(ST_NORMAL);
    over_temp = 1'h1;
    wst(ST_STANDBY);
    tk(20);
    chk({flags.thermal_shutdown_flag, state}, {1'h1, ST_STANDBY});
    over_temp = 1'h0;
    wst(ST_SOFTSTART);
    wst(ST_NORMAL);
    host.start();
    host.xfer({ADDR_BASE, 1'h0}, 1'h0, q, a);
    tk(TO - 100);
    chk(flags.serial_error_flag, 1'h0);
    tk(200);
    chk(flags.serial_error_flag, 1'h1);
    host.wr(ADDR_BASE, OFF_BRT, 16'h0100);
    chk(brightness, 16'h0100);
    boost_at_max = 1'h1;
    headroom_low = 6'h0C;
    wst(ST_LATCH);
    boost_at_max = 1'h0;
    headroom_low = 6'h00;
    host.wr(ADDR_BASE, OFF_BRT, 16'h0F0F);
    chk({state, led_drive, brightness}, {ST_LATCH, 6'h00, 16'h0100});
    en_pin = 1'h0;
    wst(ST_SHUTDOWN);
    chk({discharge_en, plfet_en, boost_en, led_drive}, {3'h4, 6'h00});
    wst(ST_OFF);
    chk({1'(n > DIS - 3 && n < DIS + 3), powered_down}, 2'h3);
    mode_addr_alt = 1'h1;
    en_pin = 1'h1;
    wst(ST_NORMAL);
    chk({string_fault_flags, led_drive}, {6'h00, 6'h0F});
    host.wr(ADDR_ALT, OFF_CFG, 16'h00B6);
    chk({host.ack, cfg}, {1'h1, 8'hB6});
    // Pin held high since reset, so any finished window reads full scale
    tk(65536);
    chk({brightness, led_drive}, {16'hFFFF, 6'h0F});
    conclude();
  end
endmodule
